// ===== design/ufc_pkg.sv
// Constants, levels and types for the UART queue and flow control block
package ufc_pkg;
    localparam int QDEPTH = 16;
    localparam int QAW = 4;
    localparam logic [5:0] ADR_DATA = 6'h00;
    localparam logic [5:0] ADR_IER = 6'h04;
    localparam logic [5:0] ADR_FCR = 6'h08;
    localparam logic [5:0] ADR_LCR = 6'h0C;
    localparam logic [5:0] ADR_EFR = 6'h10;
    localparam logic [5:0] ADR_ON1 = 6'h14;
    localparam logic [5:0] ADR_ON2 = 6'h18;
    localparam logic [5:0] ADR_OFF1 = 6'h1C;
    localparam logic [5:0] ADR_OFF2 = 6'h20;
    localparam logic [5:0] ADR_STAT = 6'h24;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] LCR_UNLOCK = 8'hBF;
    localparam int FCR_EN = 0;
    localparam int FCR_RXCLR = 1;
    localparam int FCR_TXCLR = 2;
    localparam int FCR_TXT = 4;
    localparam int FCR_RXT = 6;
    localparam int EFR_TXT = 4;
    localparam int EFR_SPEC = 5;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_OFF = 5;
    localparam int IER_RTS = 6;
    localparam int IER_CTS = 7;
    localparam logic [2:0] ID_TO = 3'h6;
    localparam logic [2:0] ID_RX = 3'h2;
    localparam logic [2:0] ID_TX = 3'h1;
    localparam logic [2:0] ID_NONE = 3'h0;
    localparam logic [5:0] TO_BASE = 6'h0C;
    localparam logic [3:0] WL_MIN = 4'h5;
    localparam logic [4:0] LV_0 = 5'h00;
    localparam logic [4:0] LV_1 = 5'h01;
    localparam logic [4:0] LV_4 = 5'h04;
    localparam logic [4:0] LV_8 = 5'h08;
    localparam logic [4:0] LV_14 = 5'h0E;

    typedef enum logic [1:0] {
        FL_IDLE = 2'b00,
        FL_FIRST = 2'b01,
        FL_SECOND = 2'b10
    } ufc_fl_e;

    function automatic logic [4:0] ufc_trig(input logic [1:0] c);
        unique case (c)
            2'b00: ufc_trig = LV_1;
            2'b01: ufc_trig = LV_4;
            2'b10: ufc_trig = LV_8;
            2'b11: ufc_trig = LV_14;
        endcase
    endfunction : ufc_trig

    function automatic logic [4:0] ufc_up(input logic [1:0] c);
        unique case (c)
            2'b00: ufc_up = LV_4;
            2'b01: ufc_up = LV_8;
            2'b10: ufc_up = LV_14;
            2'b11: ufc_up = LV_14;
        endcase
    endfunction : ufc_up

    function automatic logic [4:0] ufc_dn(input logic [1:0] c);
        unique case (c)
            2'b00: ufc_dn = LV_0;
            2'b01: ufc_dn = LV_1;
            2'b10: ufc_dn = LV_4;
            2'b11: ufc_dn = LV_8;
        endcase
    endfunction : ufc_dn
endpackage : ufc_pkg

// ===== design/ufc_queue.sv
// Sixteen-entry character queue built from flip-flops
`timescale 1ns/1ps
module ufc_queue (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic flush,
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic pop,
    output logic [7:0] head,
    output logic [4:0] count,
    output logic full,
    output logic empty
);
    localparam int QAW = ufc_pkg::QAW;
    logic [7:0] mem [ufc_pkg::QDEPTH];
    logic [ufc_pkg::QAW-1:0] wr_ptr;
    logic [ufc_pkg::QAW-1:0] rd_ptr;
    wire do_push = push & ~full;
    wire do_pop = pop & ~empty;

    assign full = count[4];
    assign empty = (count == 5'h00);
    assign head = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (clk_en && do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= 5'h00;
        end else if (clk_en) begin
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= 5'h00;
            end else begin
                wr_ptr <= wr_ptr + QAW'(do_push);
                rd_ptr <= rd_ptr + QAW'(do_pop);
                count <= count + 5'(do_push) - 5'(do_pop);
            end
        end
    end
endmodule : ufc_queue

// ===== design/ufc_top.sv
// UART queues with hardware and software flow control, Wishbone slave
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module ufc_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_stop_mid,
    input wire logic bit_tick,
    input wire logic tx_busy,
    output logic [7:0] tx_data,
    output logic tx_load,
    input wire logic cts_n,
    output logic rts_n,
    output logic irq
);
    localparam logic [7:0] REG_RST = ufc_pkg::REG_RST;
    logic [7:0] fifo_control_reg, int_enable_reg, line_control_reg, enhanced_feature_reg, on1, on2, off1, off2;
    logic cts_s1, cts_s2, cts_s3;
    logic suspended, sent_off, flag_char, flag_flow;
    logic [5:0] to_cnt;
    logic hold_v, hold_plain, hold_off;
    logic [7:0] hold_c;
    ufc_pkg::ufc_fl_e fl_state;
    logic fl_off;

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i & wb_sel_i[0];
    wire rd = req & ~wb_we_i;
    wire [7:0] wd = wb_dat_i[7:0];
    wire ext_ok = (line_control_reg == ufc_pkg::LCR_UNLOCK);
    wire wr_data = wr & (wb_adr_i == ufc_pkg::ADR_DATA);
    wire wr_ier = wr & (wb_adr_i == ufc_pkg::ADR_IER);
    wire wr_fcr = wr & (wb_adr_i == ufc_pkg::ADR_FCR);
    wire wr_lcr = wr & (wb_adr_i == ufc_pkg::ADR_LCR);
    wire wr_efr = wr & ext_ok & (wb_adr_i == ufc_pkg::ADR_EFR);
    wire wr_on1 = wr & ext_ok & (wb_adr_i == ufc_pkg::ADR_ON1);
    wire wr_on2 = wr & ext_ok & (wb_adr_i == ufc_pkg::ADR_ON2);
    wire wr_off1 = wr & ext_ok & (wb_adr_i == ufc_pkg::ADR_OFF1);
    wire wr_off2 = wr & ext_ok & (wb_adr_i == ufc_pkg::ADR_OFF2);
    wire rd_data = rd & (wb_adr_i == ufc_pkg::ADR_DATA);
    wire rd_isr = rd & (wb_adr_i == ufc_pkg::ADR_FCR);

    wire fen = fifo_control_reg[ufc_pkg::FCR_EN];
    wire fen_chg = wr_fcr & (wd[ufc_pkg::FCR_EN] != fen);
    wire rx_flush = fen_chg | (wr_fcr & wd[ufc_pkg::FCR_RXCLR]);
    wire tx_flush = fen_chg | (wr_fcr & wd[ufc_pkg::FCR_TXCLR]);

    wire [7:0] rx_head, tx_head;
    wire [4:0] rx_cnt, tx_cnt;
    wire rx_full, rx_empty, tx_full, tx_empty;
    logic rx_push;
    logic [7:0] rx_push_d;
    wire tx_pop;

    wire rx_room = fen ? ~rx_full : rx_empty;
    wire tx_room = fen ? ~tx_full : tx_empty;

    // Word-length compare mask
    wire [1:0] wl = line_control_reg[1:0];
    wire [7:0] cmask = 8'hFF >> (2'h3 - wl);
    wire [7:0] rc = rx_data & cmask;
    wire m_on1 = (rc == (on1 & cmask));
    wire m_on2 = (rc == (on2 & cmask));
    wire m_off1 = (rc == (off1 & cmask));
    wire m_off2 = (rc == (off2 & cmask));

    wire spec = enhanced_feature_reg[ufc_pkg::EFR_SPEC];
    wire sw_rx = |enhanced_feature_reg[1:0];
    wire dbl_rx = &enhanced_feature_reg[1:0];
    wire off_a = enhanced_feature_reg[1] ? m_off1 : m_off2;
    wire on_a = enhanced_feature_reg[1] ? m_on1 : m_on2;
    wire hold_hit = hold_off ? m_off2 : m_on2;
    logic off_match, on_match, spec_match;
    logic next_hold_v, next_hold_plain, next_hold_off;
    logic [7:0] next_hold_c;

    // Receive character steering
    always_comb begin
        rx_push = 1'b0;
        rx_push_d = rx_data;
        off_match = 1'b0;
        on_match = 1'b0;
        spec_match = 1'b0;
        next_hold_v = hold_v;
        next_hold_plain = hold_plain;
        next_hold_off = hold_off;
        next_hold_c = hold_c;
        if (rx_valid) begin
            if (spec) begin
                rx_push = 1'b1;
                spec_match = m_off2;
            end else if (sw_rx && !dbl_rx) begin
                off_match = off_a;
                on_match = on_a & ~off_a;
                rx_push = ~off_a & ~on_a;
            end else if (sw_rx && hold_v && !hold_plain && hold_hit) begin
                off_match = hold_off;
                on_match = ~hold_off;
                next_hold_v = 1'b0;
            end else if (sw_rx && (hold_v || m_off1 || m_on1)) begin
                rx_push = hold_v;
                rx_push_d = hold_c;
                next_hold_v = 1'b1;
                next_hold_plain = ~m_off1 & ~m_on1;
                next_hold_off = m_off1;
                next_hold_c = rx_data;
            end else begin
                rx_push = 1'b1;
            end
        end else if (hold_v && hold_plain) begin
            rx_push = 1'b1;
            rx_push_d = hold_c;
            next_hold_v = 1'b0;
        end
    end

    ufc_queue u_rxq (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .flush(rx_flush),
        .push(rx_push & rx_room),
        .push_data(rx_push_d),
        .pop(rd_data),
        .head(rx_head),
        .count(rx_cnt),
        .full(rx_full),
        .empty(rx_empty)
    );

    ufc_queue u_txq (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .flush(tx_flush),
        .push(wr_data & tx_room),
        .push_data(wd),
        .pop(tx_pop),
        .head(tx_head),
        .count(tx_cnt),
        .full(tx_full),
        .empty(tx_empty)
    );

    wire [1:0] rxt = fifo_control_reg[ufc_pkg::FCR_RXT+:2];
    wire [4:0] rx_lvl = ufc_pkg::ufc_trig(rxt);
    wire rx_hit = (rx_cnt >= rx_lvl);
    wire [4:0] tx_lvl = enhanced_feature_reg[ufc_pkg::EFR_TXT]
        ? ufc_pkg::ufc_trig(fifo_control_reg[ufc_pkg::FCR_TXT+:2]) : ufc_pkg::LV_1;
    wire tx_int = (tx_cnt < tx_lvl);

    wire [3:0] wlen = ufc_pkg::WL_MIN + {2'b00, wl};
    wire [5:0] to_lim = {wlen, 2'b00} + ufc_pkg::TO_BASE;
    wire to_flag = (to_cnt == to_lim) & ~rx_empty & ~rx_hit;

    wire a_cts = enhanced_feature_reg[ufc_pkg::EFR_ACTS];
    wire a_rts = enhanced_feature_reg[ufc_pkg::EFR_ARTS];
    wire cts_rise = cts_s2 & ~cts_s3;
    wire [4:0] rts_up = ufc_pkg::ufc_up(rxt);
    wire [4:0] rts_dn = ufc_pkg::ufc_dn(rxt);
    wire rts_off = a_rts & (rx_cnt >= rts_up);
    wire rts_on = ~a_rts | (rx_cnt <= rts_dn);
    wire next_rts_n = rts_off ? 1'b1 : (rts_on ? 1'b0 : rts_n);
    wire rts_rise = next_rts_n & ~rts_n;

    wire flow_set = (cts_rise & a_cts & int_enable_reg[ufc_pkg::IER_CTS])
        | (rts_rise & int_enable_reg[ufc_pkg::IER_RTS]);
    wire char_set = (off_match & int_enable_reg[ufc_pkg::IER_OFF]) | spec_match;

    // Transmit side
    wire tx_sw = |enhanced_feature_reg[3:2];
    wire dbl_tx = &enhanced_feature_reg[3:2];
    wire want_off = tx_sw & ~sent_off & (rx_cnt > rx_lvl);
    wire want_on = sent_off & (rx_cnt < rx_lvl);
    wire cts_halt = a_cts & cts_s2;
    wire tx_free = ~tx_busy & ~tx_load & ~cts_halt;
    wire fl_busy = (fl_state != ufc_pkg::FL_IDLE);
    wire use_first = dbl_tx | enhanced_feature_reg[3];
    wire [7:0] fl_c1 = fl_off ? (use_first ? off1 : off2)
        : (use_first ? on1 : on2);
    wire [7:0] fl_c2 = fl_off ? off2 : on2;
    wire [7:0] fl_char = (fl_state == ufc_pkg::FL_SECOND) ? fl_c2 : fl_c1;
    wire send_fl = tx_free & fl_busy;
    assign tx_pop = tx_free & ~fl_busy & ~tx_empty & ~suspended;

    // Flow character sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fl_state <= ufc_pkg::FL_IDLE;
            fl_off <= 1'b0;
            sent_off <= 1'b0;
        end else if (clk_en) begin
            unique case (fl_state)
                ufc_pkg::FL_IDLE: begin
                    if (want_off || want_on) begin
                        fl_state <= ufc_pkg::FL_FIRST;
                        fl_off <= want_off;
                        sent_off <= want_off;
                    end
                end
                ufc_pkg::FL_FIRST: begin
                    if (send_fl) begin
                        fl_state <= dbl_tx ? ufc_pkg::FL_SECOND
                            : ufc_pkg::FL_IDLE;
                    end
                end
                ufc_pkg::FL_SECOND: begin
                    if (send_fl) begin
                        fl_state <= ufc_pkg::FL_IDLE;
                    end
                end
                default: fl_state <= ufc_pkg::FL_IDLE;
            endcase
        end
    end

    // Transmit load strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_load <= 1'b0;
            tx_data <= REG_RST;
        end else if (clk_en) begin
            tx_load <= send_fl | tx_pop;
            if (send_fl) begin
                tx_data <= fl_char;
            end else if (tx_pop) begin
                tx_data <= tx_head;
            end
        end
    end

    // Control registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fifo_control_reg <= REG_RST;
            int_enable_reg <= REG_RST;
            line_control_reg <= REG_RST;
            enhanced_feature_reg <= REG_RST;
            on1 <= REG_RST;
            on2 <= REG_RST;
            off1 <= REG_RST;
            off2 <= REG_RST;
        end else if (clk_en) begin
            if (wr_fcr) fifo_control_reg <= wd & 8'hF1;
            if (wr_ier) int_enable_reg <= wd;
            if (wr_lcr) line_control_reg <= wd;
            if (wr_efr) enhanced_feature_reg <= wd;
            if (wr_on1) on1 <= wd;
            if (wr_on2) on2 <= wd;
            if (wr_off1) off1 <= wd;
            if (wr_off2) off2 <= wd;
        end
    end

    // Flow state, flags and timers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cts_s1 <= 1'b0;
            cts_s2 <= 1'b0;
            cts_s3 <= 1'b0;
            rts_n <= 1'b0;
            suspended <= 1'b0;
            flag_char <= 1'b0;
            flag_flow <= 1'b0;
            to_cnt <= 6'h00;
            hold_v <= 1'b0;
            hold_plain <= 1'b0;
            hold_off <= 1'b0;
            hold_c <= REG_RST;
        end else if (clk_en) begin
            cts_s1 <= cts_n;
            cts_s2 <= cts_s1;
            cts_s3 <= cts_s2;
            rts_n <= next_rts_n;
            hold_v <= next_hold_v;
            hold_plain <= next_hold_plain;
            hold_off <= next_hold_off;
            hold_c <= next_hold_c;
            suspended <= off_match | (suspended & ~on_match);
            flag_char <= char_set | (flag_char & ~on_match & ~rd_isr);
            flag_flow <= flow_set | (flag_flow & ~rd_isr);
            if (rx_stop_mid || rd_data) begin
                to_cnt <= 6'h00;
            end else if (bit_tick && !rx_empty && to_cnt != to_lim) begin
                to_cnt <= to_cnt + 6'h01;
            end
        end
    end

    // Status read values
    wire pend_rx = int_enable_reg[ufc_pkg::IER_RX] & (rx_hit | to_flag);
    wire pend_tx = int_enable_reg[ufc_pkg::IER_TX] & tx_int;
    wire pend = pend_rx | pend_tx | flag_char | flag_flow;
    wire [2:0] isr_id = (int_enable_reg[ufc_pkg::IER_RX] & to_flag) ? ufc_pkg::ID_TO
        : pend_rx ? ufc_pkg::ID_RX
        : pend_tx ? ufc_pkg::ID_TX : ufc_pkg::ID_NONE;
    wire [7:0] int_status_reg = {{2{fen}}, flag_flow, flag_char, isr_id, ~pend};
    wire [7:0] stat = {4'h0, sent_off, suspended, cts_s2, rts_n};
    wire [31:0] rd_mux =
        (wb_adr_i == ufc_pkg::ADR_DATA) ? {24'h0, rx_head}
        : (wb_adr_i == ufc_pkg::ADR_IER) ? {24'h0, int_enable_reg}
        : (wb_adr_i == ufc_pkg::ADR_FCR) ? {24'h0, int_status_reg}
        : (wb_adr_i == ufc_pkg::ADR_LCR) ? {24'h0, line_control_reg}
        : (wb_adr_i == ufc_pkg::ADR_EFR && ext_ok) ? {24'h0, enhanced_feature_reg}
        : (wb_adr_i == ufc_pkg::ADR_ON1 && ext_ok) ? {24'h0, on1}
        : (wb_adr_i == ufc_pkg::ADR_ON2 && ext_ok) ? {24'h0, on2}
        : (wb_adr_i == ufc_pkg::ADR_OFF1 && ext_ok) ? {24'h0, off1}
        : (wb_adr_i == ufc_pkg::ADR_OFF2 && ext_ok) ? {24'h0, off2}
        : (wb_adr_i == ufc_pkg::ADR_STAT)
            ? {8'h0, stat, 3'h0, rx_cnt, 3'h0, tx_cnt}
        : 32'h0000_0000;

    // Bus answer and interrupt output
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            irq <= 1'b0;
        end else if (clk_en) begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= rd_mux;
            end
            irq <= pend;
        end
    end
endmodule : ufc_top

// ===== testbench/ufc_peer.sv
// Serial peer model: shifter busy time and log of sent characters
`timescale 1ns/1ps
module ufc_peer (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic tx_load,
    input wire logic [7:0] tx_data,
    input wire logic slow,
    output logic tx_busy,
    output logic [7:0] last,
    output logic [7:0] n_got
);
    logic [5:0] left;
    assign tx_busy = left != 6'h00;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            left <= 6'h00;
            last <= 8'h00;
            n_got <= 8'h00;
        end else if (tx_load) begin
            left <= slow ? 6'h30 : 6'h0A;
            last <= tx_data;
            n_got <= n_got + 8'h01;
        end else if (tx_busy) begin
            left <= left - 6'h01;
        end
    end
endmodule : ufc_peer

// ===== testbench/ufc_monitor.sv
// Checker for bus, transmit and flow-control behaviour of ufc_top
`timescale 1ns/1ps
module ufc_monitor (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_busy,
    input wire logic [7:0] tx_data,
    input wire logic tx_load,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic irq
);
    logic [7:0] lcr_s;
    logic [7:0] efr_s;
    logic [7:0] ier_s;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_on = take && wb_we_i && wb_sel_i[0];
    wire open_x = lcr_s == ufc_pkg::LCR_UNLOCK;
    wire ext = wb_adr_i >= ufc_pkg::ADR_EFR && wb_adr_i <= ufc_pkg::ADR_OFF2;
    // Shadow of the controls the properties depend on
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lcr_s <= 8'h00;
            efr_s <= 8'h00;
            ier_s <= 8'h00;
        end else if (wr_on) begin
            if (wb_adr_i == ufc_pkg::ADR_LCR)
                lcr_s <= wb_dat_i[7:0];
            if (wb_adr_i == ufc_pkg::ADR_EFR && open_x)
                efr_s <= wb_dat_i[7:0];
            if (wb_adr_i == ufc_pkg::ADR_IER)
                ier_s <= wb_dat_i[7:0];
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    AST_ACK_NEXT: assert property (take |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    AST_EXT_LOCK: assert property (take && !wb_we_i && ext
        && !open_x |=> wb_dat_o == 32'h0)
        else $error("locked register read not zero");
    AST_LOAD_IDLE: assert property (tx_load |-> !$past(tx_busy))
        else $error("load issued while shifter busy");
    AST_LOAD_ONE: assert property (tx_load |=> !tx_load)
        else $error("load longer than one cycle");
    AST_LOAD_HOLD: assert property (!tx_load |-> $stable(tx_data))
        else $error("transmit data changed without load");
    AST_CTS_HALT: assert property (
        (efr_s[7] && cts_n) [*5] |=> !tx_load)
        else $error("load while clear-to-send is off");
    AST_CTS_FLAG: assert property (
        efr_s[7] && ier_s[7] && $rose(cts_n) |-> ##[1:8] irq)
        else $error("no interrupt on clear-to-send rise");
    AST_RTS_OFF: assert property ((!efr_s[6]) [*3] |-> !rts_n)
        else $error("rts off while auto rts disabled");

    cover property (tx_load);
    cover property ($rose(rts_n));
    cover property (take && wb_we_i && open_x);
endmodule : ufc_monitor

bind ufc_top ufc_monitor i_mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_busy(tx_busy), .tx_data(tx_data),
    .tx_load(tx_load), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));

// ===== testbench/tb_uart_fifo_flow_control.sv
// Random and corner-case bench for the queue and flow control block
`timescale 1ns/1ps
module tb_uart_fifo_flow_control;
    logic ref_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic we = 1'b0, rx_valid = 1'b0, rx_stop_mid = 1'b0;
    logic bit_tick = 1'b0, cts_n = 1'b0, slow = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic [7:0] rx_data = 8'h00, tx_data, last, n_got, d;
    logic ack, tx_load, tx_busy, rts_n, irq;
    logic [1:0] phase = 2'h0;
    logic [7:0] q[$];
    int errors = 0, n_tests = 0, cycles = 0, seed = 6;

    ufc_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_stop_mid(rx_stop_mid),
        .bit_tick(bit_tick), .tx_busy(tx_busy), .tx_data(tx_data),
        .tx_load(tx_load), .cts_n(cts_n), .rts_n(rts_n), .irq(irq));
    ufc_peer i_peer (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
        .tx_load(tx_load), .tx_data(tx_data), .tx_busy(tx_busy),
        .last(last), .n_got(n_got));

    always #10 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        phase <= phase + 2'h1;
        bit_tick <= phase == 2'h3;
        cycles++;
        if (cycles > 20000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [5:0] a, logic [7:0] v);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= {24'h0, v};
        do @(posedge ref_clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic rx_put(input logic [7:0] v);
        rx_valid <= 1'b1;
        rx_stop_mid <= 1'b1;
        rx_data <= v;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_stop_mid <= 1'b0;
        rx_data <= ~v;
        repeat (6) @(posedge ref_clk);
    endtask : rx_put

    task automatic wait_got(input logic [7:0] n);
        for (int k = 0; k < 300 && n_got !== n; k++)
            @(posedge ref_clk);
    endtask : wait_got

    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        bus(1, ufc_pkg::ADR_LCR, 8'h03);
        bus(1, ufc_pkg::ADR_EFR, 8'hFF);
        bus(1, ufc_pkg::ADR_LCR, ufc_pkg::LCR_UNLOCK);
        for (int i = 0; i < 5; i++) begin
            bus(0, ufc_pkg::ADR_EFR + 6'(4 * i), 8'h00);
            chk("ext reg", 32'h0, r);
        end
        bus(1, ufc_pkg::ADR_OFF1, 8'h13);
        bus(1, ufc_pkg::ADR_ON1, 8'h11);
        bus(1, ufc_pkg::ADR_FCR, 8'h01);
        bus(1, ufc_pkg::ADR_EFR, 8'h40);
        bus(1, ufc_pkg::ADR_IER, 8'h01);
        for (int i = 1; i <= 17; i++) begin
            d = 8'($random(seed));
            if (i <= 16)
                q.push_back(d);
            rx_put(d);
            chk("rts fill", 32'(i >= 4), 32'(rts_n));
            if (i == 1)
                chk("rx irq", 32'h1, 32'(irq));
        end
        bus(0, ufc_pkg::ADR_STAT, 8'h00);
        chk("rx count", 32'h10, 32'(r[12:8]));
        for (int i = 15; i >= 0; i--) begin
            bus(0, ufc_pkg::ADR_DATA, 8'h00);
            chk("rx data", 32'(q.pop_front()), r);
            chk("rts drain", 32'(i > 0), 32'(rts_n));
        end
        bus(1, ufc_pkg::ADR_EFR, 8'h02);
        bus(1, ufc_pkg::ADR_IER, 8'h21);
        rx_put(8'h13);
        chk("pause irq", 32'h1, 32'(irq));
        bus(0, ufc_pkg::ADR_STAT, 8'h00);
        chk("suspended", 32'h1, 32'(r[18]));
        chk("pause kept out", 32'h0, 32'(r[12:8]));
        d = 8'($random(seed));
        bus(1, ufc_pkg::ADR_DATA, d);
        repeat (20) @(posedge ref_clk);
        chk("held by pause", 32'h0, 32'(n_got));
        rx_put(8'h11);
        wait_got(8'h01);
        chk("sent on resume", 32'(d), 32'(last));
        bus(0, ufc_pkg::ADR_FCR, 8'h00);
        chk("pause flag", 32'h0, 32'(r[4]));
        bus(1, ufc_pkg::ADR_EFR, 8'h80);
        bus(1, ufc_pkg::ADR_IER, 8'h80);
        slow <= 1'b1;
        cts_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        bus(0, ufc_pkg::ADR_FCR, 8'h00);
        chk("cts flag", 32'h1, 32'(r[5]));
        d = 8'($random(seed));
        bus(1, ufc_pkg::ADR_DATA, d);
        repeat (20) @(posedge ref_clk);
        chk("held by cts", 32'h1, 32'(n_got));
        cts_n <= 1'b0;
        wait_got(8'h02);
        chk("sent on cts", 32'(d), 32'(last));
        bus(1, ufc_pkg::ADR_EFR, 8'h00);
        bus(1, ufc_pkg::ADR_IER, 8'h01);
        bus(1, ufc_pkg::ADR_FCR, 8'h41);
        rx_put(8'($random(seed)));
        repeat (110) @(posedge ref_clk);
        chk("early timeout", 32'h0, 32'(irq));
        repeat (90) @(posedge ref_clk);
        bus(0, ufc_pkg::ADR_FCR, 8'h00);
        chk("timeout id", 32'(ufc_pkg::ID_TO), 32'(r[3:1]));
        bus(0, ufc_pkg::ADR_DATA, 8'h00);
        repeat (250) @(posedge ref_clk);
        chk("empty timeout", 32'h0, 32'(irq));
        bus(1, ufc_pkg::ADR_EFR, 8'h08);
        repeat (5) rx_put(8'h41);
        wait_got(8'h03);
        chk("pause sent", 32'h13, 32'(last));
        repeat (5) bus(0, ufc_pkg::ADR_DATA, 8'h00);
        wait_got(8'h04);
        chk("resume sent", 32'h11, 32'(last));
        // special character match in special mode: flag set, character stored, no flow off
        bus(1, ufc_pkg::ADR_EFR, 8'h20);
        bus(1, ufc_pkg::ADR_OFF2, 8'h5A);
        rx_put(8'h5A);
        bus(0, ufc_pkg::ADR_FCR, 8'h00);
        chk("special flag", 32'h1, 32'(r[4]));
        bus(0, ufc_pkg::ADR_DATA, 8'h00);
        chk("special stored", 32'h5A, r);
        test_done();
    end
endmodule : tb_uart_fifo_flow_control
